/* File: hw/imd_mul_datapath.sv */
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module imd_mul_datapath #(
    parameter int ADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic result_valid,
    output logic sticky_saturation_flag
);

    // --------------------------------------------------------------
    // elaboration check
    // --------------------------------------------------------------
    if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
        $error("address width must be 8 to 32");
    end

    // --------------------------------------------------------------
    // declarations
    // --------------------------------------------------------------
    logic [imd_pkg::CTRL_W-1:0] ctrl_r;
    logic [31:0] opa_r;
    logic [31:0] opb_r;
    logic [31:0] dlo_r;
    logic [31:0] dhi_r;
    logic [31:0] res_lo_r;
    logic [31:0] res_hi_r;
    logic [imd_pkg::FLAGS_W-1:0] flags_r;
    logic sat_r;
    logic valid_r;
    logic go_r;
    logic result_valid_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic acc_phase;
    logic xfer_wr;
    logic [7:0] ofs;
    logic hit;
    logic [31:0] rd_data;
    imd_pkg::imd_op_t op_sel;
    logic swap;
    logic fsel;
    logic ssel;
    logic rnd;
    logic signed [15:0] b_p0;
    logic signed [15:0] b_p1;
    logic signed [31:0] p0;
    logic signed [31:0] p1;
    logic signed [31:0] hp;
    logic signed [32:0] dsum;
    logic signed [47:0] wh;
    logic signed [63:0] sa;
    logic signed [63:0] sb;
    logic [63:0] uprod;
    logic [63:0] sprod;
    logic [63:0] tprod;
    logic [63:0] acc;
    logic [63:0] res;
    logic ovf;
    logic is_long;
    logic op_ok;

    // pick a signed halfword, top when sel is high
    function automatic logic signed [15:0] half_of(
        input logic [31:0] w,
        input logic sel
    );
        half_of = sel ? $signed(w[31:16]) : $signed(w[15:0]);
    endfunction

    // --------------------------------------------------------------
    // apb slave
    // --------------------------------------------------------------
    assign acc_phase = psel & penable;
    assign xfer_wr = acc_phase & pready_r & pwrite & hit;
    assign ofs = paddr[7:0];

    // decode: upper address bits must be zero
    always_comb begin
        hit = (paddr >> 8) == '0;
        rd_data = 32'h0000_0000;
        case (ofs)
            imd_pkg::CTRL_OFS: rd_data = {24'h00_0000, ctrl_r};
            imd_pkg::OPA_OFS: rd_data = opa_r;
            imd_pkg::OPB_OFS: rd_data = opb_r;
            imd_pkg::DLO_OFS: rd_data = dlo_r;
            imd_pkg::DHI_OFS: rd_data = dhi_r;
            imd_pkg::RLO_OFS: rd_data = res_lo_r;
            imd_pkg::RHI_OFS: rd_data = res_hi_r;
            imd_pkg::STAT_OFS: begin
                rd_data[imd_pkg::STAT_SAT_BIT] = sat_r;
                rd_data[imd_pkg::STAT_VALID_BIT] = valid_r;
                rd_data[imd_pkg::STAT_BUSY_BIT] = go_r;
            end
            imd_pkg::START_OFS: rd_data = 32'h0000_0000;
            imd_pkg::FLAGS_OFS: rd_data = {28'h000_0000, flags_r};
            default: hit = 1'b0;
        endcase
    end

    // one wait state, then ready with data and error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= imd_pkg::WORD_RST;
        end else begin
            pready_r <= acc_phase & ~pready_r;
            pslverr_r <= acc_phase & ~pready_r & ~hit;
            if (acc_phase && !pready_r && !pwrite) begin
                prdata_r <= hit ? rd_data : 32'h0000_0000;
            end
        end
    end

    // --------------------------------------------------------------
    // operand and control registers
    // --------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= imd_pkg::CTRL_RST;
            opa_r <= imd_pkg::WORD_RST;
            opb_r <= imd_pkg::WORD_RST;
            flags_r <= imd_pkg::FLAGS_RST;
        end else if (xfer_wr) begin
            case (ofs)
                imd_pkg::CTRL_OFS: ctrl_r <= pwdata[imd_pkg::CTRL_W-1:0];
                imd_pkg::OPA_OFS: opa_r <= pwdata;
                imd_pkg::OPB_OFS: opb_r <= pwdata;
                // only software touches the condition flags
                imd_pkg::FLAGS_OFS: begin
                    flags_r <= pwdata[imd_pkg::FLAGS_W-1:0];
                end
                default: ;
            endcase
        end
    end

    // start pulse from a write to the start register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            go_r <= 1'b0;
        end else begin
            go_r <= xfer_wr && ofs == imd_pkg::START_OFS &&
                pwdata[imd_pkg::START_GO_BIT];
        end
    end

    // --------------------------------------------------------------
    // multiply datapath
    // --------------------------------------------------------------
    assign op_sel = imd_pkg::imd_op_t'(
        ctrl_r[imd_pkg::CTRL_OP_LSB +: imd_pkg::CTRL_OP_W]);
    assign swap = ctrl_r[imd_pkg::CTRL_SWAP_BIT];
    assign fsel = ctrl_r[imd_pkg::CTRL_FSEL_BIT];
    assign ssel = ctrl_r[imd_pkg::CTRL_SSEL_BIT];
    assign rnd = ctrl_r[imd_pkg::CTRL_RND_BIT];

    // all products from the current operand registers
    always_comb begin
        b_p0 = half_of(opb_r, swap);
        b_p1 = half_of(opb_r, ~swap);
        p0 = half_of(opa_r, 1'b0) * b_p0;
        p1 = half_of(opa_r, 1'b1) * b_p1;
        dsum = 33'(p0) + 33'(p1);
        ovf = dsum[32] ^ dsum[31];
        hp = half_of(opa_r, fsel) * half_of(opb_r, ssel);
        wh = $signed(opa_r) * half_of(opb_r, ssel);
        uprod = {32'h0000_0000, opa_r} * {32'h0000_0000, opb_r};
        sa = 64'($signed(opa_r));
        sb = 64'($signed(opb_r));
        sprod = 64'(sa * sb);
        tprod = sprod + (rnd ? imd_pkg::ROUND_ADD : 64'h0);
        acc = {dhi_r, dlo_r};
        res = 64'h0;
        is_long = 1'b0;
        op_ok = 1'b1;
        case (op_sel)
            imd_pkg::OP_DUAL_ADD: res = {32'h0, dsum[31:0]};
            imd_pkg::OP_DUAL_SUB: res = {32'h0, p0 - p1};
            imd_pkg::OP_HALF_MUL: res = {32'h0, hp};
            imd_pkg::OP_WORD_HALF: res = {32'h0, wh[47:16]};
            imd_pkg::OP_TOP_WORD: res = {32'h0, tprod[63:32]};
            imd_pkg::OP_ULONG_MUL: begin
                res = uprod;
                is_long = 1'b1;
            end
            imd_pkg::OP_ULONG_MAC: begin
                res = uprod + acc;
                is_long = 1'b1;
            end
            imd_pkg::OP_SLONG_MUL: begin
                res = sprod;
                is_long = 1'b1;
            end
            imd_pkg::OP_SLONG_MAC: begin
                res = sprod + acc;
                is_long = 1'b1;
            end
            default: op_ok = 1'b0;
        endcase
    end

    // --------------------------------------------------------------
    // writeback
    // --------------------------------------------------------------
    // result words and valid strobe one cycle after start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_lo_r <= imd_pkg::WORD_RST;
            res_hi_r <= imd_pkg::WORD_RST;
            result_valid_r <= 1'b0;
        end else begin
            result_valid_r <= go_r & op_ok;
            if (go_r && op_ok) begin
                res_lo_r <= res[31:0];
                res_hi_r <= res[63:32];
            end
        end
    end

    // destination pair: software load, long ops write back
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dlo_r <= imd_pkg::WORD_RST;
            dhi_r <= imd_pkg::WORD_RST;
        end else if (go_r && op_ok && is_long) begin
            dlo_r <= res[31:0];
            dhi_r <= res[63:32];
        end else if (xfer_wr && ofs == imd_pkg::DLO_OFS) begin
            dlo_r <= pwdata;
        end else if (xfer_wr && ofs == imd_pkg::DHI_OFS) begin
            dhi_r <= pwdata;
        end
    end

    // sticky saturation: set wins over write-one-to-clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sat_r <= 1'b0;
        end else if (go_r && op_sel == imd_pkg::OP_DUAL_ADD && ovf) begin
            sat_r <= 1'b1;
        end else if (xfer_wr && ofs == imd_pkg::STAT_OFS &&
                pwdata[imd_pkg::STAT_SAT_BIT]) begin
            sat_r <= 1'b0;
        end
    end

    // status valid: set on result, cleared by next start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            valid_r <= 1'b0;
        end else if (go_r) begin
            valid_r <= op_ok;
        end else if (xfer_wr && ofs == imd_pkg::START_OFS) begin
            valid_r <= 1'b0;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign result_valid = result_valid_r;
    assign sticky_saturation_flag = sat_r;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    // independent reference products
    logic signed [31:0] ref_sum_bb_tt;
    logic signed [31:0] ref_dif_bt_tb;
    logic signed [47:0] ref_wt;
    logic signed [63:0] ref_s64;
    logic [31:0] ref_wt_top;
    logic [31:0] ref_trunc;
    logic [63:0] ref_mac;
    assign ref_sum_bb_tt = $signed(opa_r[15:0]) * $signed(opb_r[15:0])
        + $signed(opa_r[31:16]) * $signed(opb_r[31:16]);
    assign ref_dif_bt_tb = $signed(opa_r[15:0]) * $signed(opb_r[31:16])
        - $signed(opa_r[31:16]) * $signed(opb_r[15:0]);
    assign ref_wt = $signed(opa_r) * $signed(opb_r[31:16]);
    assign ref_wt_top = ref_wt[47:16];
    assign ref_s64 = $signed(opa_r) * $signed(opb_r);
    assign ref_trunc = ref_s64[63:32];
    assign ref_mac = 64'(ref_s64) + {dhi_r, dlo_r};

    chk_dual_add_sum: assert property (
        @(posedge pclk) disable iff (!presetn)
        go_r && op_sel == imd_pkg::OP_DUAL_ADD && !swap
        |=> res_lo_r == $past(ref_sum_bb_tt) && result_valid_r)
        else $error("dual add result wrong");

    chk_dual_sub_swap: assert property (
        @(posedge pclk) disable iff (!presetn)
        go_r && op_sel == imd_pkg::OP_DUAL_SUB && swap
        |=> res_lo_r == $past(ref_dif_bt_tb))
        else $error("swapped dual sub result wrong");

    chk_sat_on_ovf: assert property (
        @(posedge pclk) disable iff (!presetn)
        go_r && op_sel == imd_pkg::OP_DUAL_ADD |=> sat_r == ($past(ovf)
        || $past(sat_r) && !$past(xfer_wr && ofs == imd_pkg::STAT_OFS &&
        pwdata[imd_pkg::STAT_SAT_BIT])))
        else $error("saturation flag not tied to overflow");

    chk_sat_sticky: assert property (
        @(posedge pclk) disable iff (!presetn)
        sat_r && !(xfer_wr && ofs == imd_pkg::STAT_OFS) |=> sat_r)
        else $error("saturation flag dropped without clear");

    chk_flags_kept: assert property (
        @(posedge pclk) disable iff (!presetn)
        go_r |=> $stable(flags_r))
        else $error("condition flags changed by multiply");

    chk_word_half_top: assert property (
        @(posedge pclk) disable iff (!presetn)
        go_r && op_sel == imd_pkg::OP_WORD_HALF && ssel
        |=> res_lo_r == $past(ref_wt_top))
        else $error("word by half result wrong");

    chk_top_round: assert property (
        @(posedge pclk) disable iff (!presetn)
        go_r && op_sel == imd_pkg::OP_TOP_WORD
        |=> res_lo_r - $past(ref_trunc) == {31'h0, $past(rnd & sprod[31])})
        else $error("top word rounding wrong");

    chk_long_mac: assert property (
        @(posedge pclk) disable iff (!presetn)
        go_r && op_sel == imd_pkg::OP_SLONG_MAC
        |=> {dhi_r, dlo_r} == $past(ref_mac))
        else $error("signed accumulate pair wrong");

    chk_valid_pulse: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(result_valid_r) |-> $past(go_r) ##1 !result_valid_r)
        else $error("result valid not a one cycle pulse");
endmodule
`default_nettype wire

/* File: hw/imd_pkg.sv */
package imd_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] OPA_OFS = 8'h04;
    localparam logic [7:0] OPB_OFS = 8'h08;
    localparam logic [7:0] DLO_OFS = 8'h0c;
    localparam logic [7:0] DHI_OFS = 8'h10;
    localparam logic [7:0] RLO_OFS = 8'h14;
    localparam logic [7:0] RHI_OFS = 8'h18;
    localparam logic [7:0] STAT_OFS = 8'h1c;
    localparam logic [7:0] START_OFS = 8'h20;
    localparam logic [7:0] FLAGS_OFS = 8'h24;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_OP_W = 4;
    localparam int CTRL_SWAP_BIT = 4;
    localparam int CTRL_FSEL_BIT = 5;
    localparam int CTRL_SSEL_BIT = 6;
    localparam int CTRL_RND_BIT = 7;
    localparam int CTRL_W = 8;
    localparam int STAT_SAT_BIT = 0;
    localparam int STAT_VALID_BIT = 1;
    localparam int STAT_BUSY_BIT = 2;
    localparam int START_GO_BIT = 0;
    localparam int FLAGS_W = 4;

    // ------------------------------------------------------------
    // reset values and constants
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    localparam logic [3:0] FLAGS_RST = 4'h0;
    localparam logic [63:0] ROUND_ADD = 64'h0000_0000_8000_0000;
    localparam int RESULT_LATENCY = 1;

    // ------------------------------------------------------------
    // operation select
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_DUAL_ADD,
        OP_DUAL_SUB,
        OP_HALF_MUL,
        OP_WORD_HALF,
        OP_TOP_WORD,
        OP_ULONG_MUL,
        OP_ULONG_MAC,
        OP_SLONG_MUL,
        OP_SLONG_MAC
    } imd_op_t;

endpackage

/* File: tb/imd_issue_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// decode and register file side issuer
// ----------------------------------------
module imd_issue_model (
    input wire logic pclk,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    output logic hang
);
    // idle bus from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        hang = 1'b0;
    end
    // one apb transfer; operands and dest words sit in distinct
    // registers, never a stack or program pointer
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // ready sampled at the rising edge that completes the transfer
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        if (pready !== 1'b1) begin
            hang <= 1'b1;
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    // ----------------------------------------
    // clock, reset and wiring
    // ----------------------------------------
    typedef struct {
        logic [3:0] op;
        logic [3:0] f;
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] lo;
        logic [31:0] hi;
    } imd_vec_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, result_valid, sat, hang;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic e;
    int miscompares = 0;
    int tests_run = 0;
    imd_vec_t tbl [17];
    logic [7:0] offs [7];
    always #5 pclk = ~pclk;
    imd_mul_datapath u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .result_valid(result_valid),
        .sticky_saturation_flag(sat));
    imd_issue_model u_pm (.pclk(pclk), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .hang(hang));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task finish_test;
        if (miscompares == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // a stuck bus ends the run
    always @(posedge hang) begin
        miscompares++;
        finish_test();
    end
    task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        tests_run++;
        if (g !== x) begin
            $display("[ERR] %s expected %h seen %h", nm, x, g);
            miscompares++;
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        u_pm.xfer(1'b1, a, d, q, e);
    endtask
    task rd(input logic [7:0] a);
        u_pm.xfer(1'b0, a, 32'h0, q, e);
    endtask
    // count result strobes over a bounded window
    task pulses(output int n);
        n = 0;
        repeat (8) begin
            @(negedge pclk);
            if (result_valid === 1'b1) n++;
        end
    endtask
    // reference arithmetic of every operation
    function automatic logic [63:0] model(input imd_vec_t v);
        logic signed [15:0] b0, b1, x, y;
        logic signed [31:0] m0, m1;
        logic signed [63:0] p, w, r;
        b0 = v.f[0] ? v.b[31:16] : v.b[15:0];
        b1 = v.f[0] ? v.b[15:0] : v.b[31:16];
        x = v.f[1] ? v.a[31:16] : v.a[15:0];
        y = v.f[2] ? v.b[31:16] : v.b[15:0];
        m0 = $signed(v.a[15:0]) * b0;
        m1 = $signed(v.a[31:16]) * b1;
        p = $signed(v.a) * $signed(v.b);
        w = $signed(v.a) * y;
        r = p + (v.f[3] ? 64'h8000_0000 : 64'h0);
        case (v.op)
            4'h0: return {32'h0, m0 + m1};
            4'h1: return {32'h0, m0 - m1};
            4'h2: begin
                m0 = x * y;
                return {32'h0, m0};
            end
            4'h3: return {32'h0, w[47:16]};
            4'h4: return {32'h0, r[63:32]};
            4'h5: return {32'h0, v.a} * {32'h0, v.b};
            4'h6: return {32'h0, v.a} * {32'h0, v.b} + {v.hi, v.lo};
            4'h7: return p;
            4'h8: return p + {v.hi, v.lo};
            default: return 64'h0;
        endcase
    endfunction
    task run(input imd_vec_t v);
        logic [63:0] x;
        int n;
        x = model(v);
        wr(imd_pkg::CTRL_OFS, {24'h0, v.f, v.op});
        wr(imd_pkg::OPA_OFS, v.a);
        wr(imd_pkg::OPB_OFS, v.b);
        wr(imd_pkg::DLO_OFS, v.lo);
        wr(imd_pkg::DHI_OFS, v.hi);
        wr(imd_pkg::START_OFS, 32'h1);
        pulses(n);
        chk("valid pulses", 32'h1, n);
        rd(imd_pkg::RLO_OFS);
        chk("result low", x[31:0], q);
        rd(imd_pkg::RHI_OFS);
        chk("result high", x[63:32], q);
        rd(imd_pkg::DLO_OFS);
        chk("dest low", (v.op > 4'h4) ? x[31:0] : v.lo, q);
        rd(imd_pkg::DHI_OFS);
        chk("dest high", (v.op > 4'h4) ? x[63:32] : v.hi, q);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        int n;
        tbl = '{
        '{4'h0,4'h0,32'h7fff0003,32'h00020005,32'h0,32'h0},
        '{4'h0,4'h1,32'h7fff0003,32'h00020005,32'h0,32'h0},
        '{4'h1,4'h0,32'hffff0004,32'h0003fffe,32'h0,32'h0},
        '{4'h1,4'h1,32'hffff0004,32'h0003fffe,32'h0,32'h0},
        '{4'h1,4'h0,32'h80008000,32'h80008000,32'h0,32'h0},
        '{4'h2,4'h0,32'h80010007,32'hfff90300,32'h0,32'h0},
        '{4'h2,4'h2,32'h80010007,32'hfff90300,32'h0,32'h0},
        '{4'h2,4'h4,32'h80010007,32'hfff90300,32'h0,32'h0},
        '{4'h2,4'h6,32'h80010007,32'hfff90300,32'h0,32'h0},
        '{4'h3,4'h0,32'h80000001,32'h7fff8000,32'h0,32'h0},
        '{4'h3,4'h4,32'h80000001,32'h7fff8000,32'h0,32'h0},
        '{4'h4,4'h0,32'h00018000,32'h00010000,32'h0,32'h0},
        '{4'h4,4'h8,32'h00018000,32'h00010000,32'h0,32'h0},
        '{4'h5,4'h0,32'hffffffff,32'hffffffff,32'h0,32'h0},
        '{4'h6,4'h0,32'hffffffff,32'hffffffff,32'hffffffff,32'h1},
        '{4'h7,4'h0,32'hfffffffe,32'h00000003,32'h0,32'h0},
        '{4'h8,4'h0,32'hfffffffe,32'h00000003,32'h5,32'h0}};
        offs = '{imd_pkg::CTRL_OFS, imd_pkg::OPA_OFS, imd_pkg::DLO_OFS,
            imd_pkg::RLO_OFS, imd_pkg::RHI_OFS, imd_pkg::STAT_OFS,
            imd_pkg::FLAGS_OFS};
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        // reset values, read-only result word, unmapped place
        wr(imd_pkg::RLO_OFS, 32'hffff_ffff);
        foreach (offs[i]) begin
            rd(offs[i]);
            chk("reset value", 32'h0, q);
        end
        rd(8'h28);
        chk("unmapped data", 32'h0, q);
        chk("unmapped error", 32'h1, {31'h0, e});
        for (int i = 0; i < 17; i++) begin
            run(tbl[i]);
        end
        chk("sat after products", 32'h0, {31'h0, sat});
        // overflowing dual add, then flags and sticky behaviour
        wr(imd_pkg::FLAGS_OFS, 32'ha);
        run(imd_vec_t'{4'h0,4'h0,32'h80008000,32'h80008000,
            32'h0,32'h0});
        chk("sat set", 32'h1, {31'h0, sat});
        rd(imd_pkg::STAT_OFS);
        chk("status sat", 32'h3, q);
        run(imd_vec_t'{4'h4,4'h8,32'h00018000,32'h00010000,
            32'h0,32'h0});
        rd(imd_pkg::FLAGS_OFS);
        chk("flags kept", 32'ha, q);
        chk("sat held", 32'h1, {31'h0, sat});
        wr(imd_pkg::STAT_OFS, 32'h1);
        rd(imd_pkg::STAT_OFS);
        chk("sat cleared", 32'h2, q);
        chk("sat port clear", 32'h0, {31'h0, sat});
        // unknown operation gives no result strobe
        wr(imd_pkg::CTRL_OFS, 32'h9);
        wr(imd_pkg::START_OFS, 32'h1);
        pulses(n);
        chk("refused op", 32'h0, n);
        finish_test();
    end
endmodule
`default_nettype wire
